// ==== rtl/iod_pkg.sv ====
// constants and encodings of the I/O decoder and node identifier generator
// Functional notes
// - ROM segment from addr[17:15] into seven segments, gated by per-segment read/write enable
// - cacheable requests to the ROM segment region go on to the DRAM decoder
// - ROM segment hit routes to one programmable node identifier, memory-mapped attribute
// - socket config hits on valid bit 19 low alias, or bit 20 with protected alias
// - chipset config hits on valid bit 21 low alias, or bit 22 with protected alias
// - 1 MB local config region hits in low or protected alias with no valid bit, forced to local configuration agent, MMIO
// - lowest 64 KB of local config is the abort page: reads ones, writes dropped
// - cacheable abort-page access must not allocate in the last-level cache
// - local config registers reachable through windows at addr[31:16] 0xfeb1 to 0xfeb3
// - interrupt controller region hits on valid bit 23, list index addr[15:13]
// - legacy hub region hits on valid bit 1, one programmable node identifier, MMIO
// - 16 MB firmware region hits on valid bit 24, list index addr[23:21]
// - disabled hole regions hit nothing and are not passed to DRAM
// - legacy I/O entry is hit only by legacy I/O space requests
// - reset clears all valid bits except bit 2, and all enable/config registers
// - node id: bit4 zero for sockets, bits 3:2 socket, bits 1:0 device
// - DRAM index: xor of addr[8:6] with addr[18:16], or addr[8:6] when select set
// - listed nibble taken from target list bits index*4+3 down to index*4
// - node id from listed bits plus base bit; interleave mode xors slice bit into bit 1
// - list entries index from fixed address bits; index select treated as set
// - fixed-target entries take node id from address or programmed registers
package iod_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_VALID = 8'h00;
  localparam logic [7:0] OFF_BASE_CFG = 8'h04;
  localparam logic [7:0] OFF_ROM_EN = 8'h08;
  localparam logic [7:0] OFF_COMPAT_EN = 8'h0c;
  localparam logic [7:0] OFF_ROM_NODE = 8'h10;
  localparam logic [7:0] OFF_HUB_NODE = 8'h14;
  localparam logic [7:0] OFF_SOCK_LIST = 8'h18;
  localparam logic [7:0] OFF_CHIP_LIST = 8'h1c;
  localparam logic [7:0] OFF_INTC_LIST = 8'h20;
  localparam logic [7:0] OFF_FW_LIST = 8'h24;
  localparam logic [7:0] OFF_LIST_PAY = 8'h28;
  localparam logic [7:0] OFF_DRAM_PAY = 8'h2c;
  localparam logic [7:0] OFF_DRAM_LIST = 8'h30;
  localparam logic [7:0] OFF_SOCKET_ID = 8'h34;
  localparam logic [7:0] OFF_LAST = 8'h38;
  localparam logic [7:0] OFF_MISS_CNT = 8'h3c;
  // reset values
  localparam logic [31:0] VALID_RST = 32'h0000_0004;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  // entry-valid bit positions
  localparam int VB_HUB = 1;
  localparam int VB_LEGIO = 2;
  localparam int VB_SOCK_LO = 19;
  localparam int VB_SOCK_PR = 20;
  localparam int VB_CHIP_LO = 21;
  localparam int VB_CHIP_PR = 22;
  localparam int VB_INTC = 23;
  localparam int VB_FW = 24;
  // payload field positions
  localparam int PAY_IDBASE = 0;
  localparam int PAY_HEMI = 1;
  localparam int PAY_TGTSEL = 2;
  localparam int ROM_WR_LSB = 7;
  // upper address aliases
  localparam logic [11:0] UP_LOW = 12'h000;
  localparam logic [11:0] UP_PROT = 12'hff0;
  // region bases, compared on the named address slices
  localparam logic [5:0] HOLE_31_26 = 6'h3f;
  localparam logic [7:0] FW_31_24 = 8'hff;
  localparam logic [7:0] SOCK_31_24 = 8'hfc;
  localparam logic [7:0] CHIP_31_24 = 8'hfd;
  localparam logic [11:0] LCFG_31_20 = 12'hfeb;
  localparam logic [11:0] INTC_31_20 = 12'hfec;
  localparam logic [11:0] HUB_31_20 = 12'hfed;
  localparam logic [23:0] ROM_43_20 = 24'h00_0000;
  localparam logic [1:0] ROM_19_18 = 2'b11;
  localparam logic [3:0] ABORT_19_16 = 4'h0;
  localparam logic [3:0] CSR_WIN_LO = 4'h1;
  localparam logic [3:0] CSR_WIN_HI = 4'h3;
  // device codes in node_identifier[1:0]
  localparam logic [1:0] DEV_CHIPSET = 2'b00;
  localparam logic [1:0] DEV_CFG_AGENT = 2'b10;
  localparam logic [7:0] CNT_ONE = 8'h01;

  typedef enum logic [1:0] {
    ATTR_MMIO = 2'b00,
    ATTR_CFG = 2'b01,
    ATTR_IO = 2'b10,
    ATTR_DRAM = 2'b11
  } iod_attr_type;

  typedef enum logic [3:0] {
    ENT_NONE = 4'h0,
    ENT_ROM = 4'h1,
    ENT_SOCK = 4'h2,
    ENT_CHIP = 4'h3,
    ENT_LCFG = 4'h4,
    ENT_INTC = 4'h5,
    ENT_HUB = 4'h6,
    ENT_FW = 4'h7,
    ENT_LEGIO = 4'h8,
    ENT_DRAM = 4'h9
  } iod_entry_type;
endpackage

// ==== rtl/iod_decoder.sv ====
// I/O decoder with node identifier generation and an Avalon-MM register slave
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
module iod_decoder (
  input wire logic clk_in, // 250 MHz uncore clock
  input wire logic sys_rst_in, // synchronous reset, active high
  input wire logic [7:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  input wire logic req_valid_in, // core request strobe
  input wire logic [43:0] req_addr_in, // physical address
  input wire logic req_write_in, // write, else read
  input wire logic req_cacheable_in, // cacheable request
  input wire logic req_protected_in, // protected_mode request
  input wire logic req_io_space_in, // legacy I/O address space
  input wire logic req_slice_hemi_in, // slice id bit 2 of requester
  output logic rsp_valid_out, // decode result strobe
  output logic [4:0] rsp_node_id_out, // destination node_identifier
  output iod_pkg::iod_attr_type rsp_attr_out, // attribute
  output iod_pkg::iod_entry_type rsp_entry_out, // matched entry
  output logic rsp_dram_out, // routed through the DRAM decoder
  output logic rsp_miss_out, // decode miss
  output logic rsp_abort_out, // abort page: read ones, drop write
  output logic rsp_no_alloc_out, // do not allocate in last-level cache
  output logic rsp_csr_window_out // local register window hit
);
  typedef struct packed {
    logic [31:0] valid;
    logic [31:0] base_cfg;
    logic [13:0] rom_en;
    logic [31:0] compat_en;
    logic [4:0] rom_node;
    logic [4:0] hub_node;
    logic [31:0] sock_list;
    logic [31:0] chip_list;
    logic [31:0] intc_list;
    logic [31:0] fw_list;
    logic [2:0] list_pay;
    logic [2:0] dram_pay;
    logic [31:0] dram_list;
    logic [1:0] socket_id;
    logic [15:0] last;
    logic [15:0] miss_cnt;
    logic wait_n;
    logic [31:0] rdata;
    logic rsp_valid;
    logic [4:0] rsp_node;
    iod_pkg::iod_attr_type rsp_attr;
    iod_pkg::iod_entry_type rsp_entry;
    logic rsp_dram;
    logic rsp_miss;
    logic rsp_abort;
    logic rsp_no_alloc;
    logic rsp_csr_win;
  } iod_state_type;

  iod_state_type st_q;
  iod_state_type st_d;

  // nibble at index*4+3 .. index*4
  function automatic logic [3:0] iod_pick(input logic [31:0] list, input logic [2:0] idx);
    logic [3:0] nib;
    nib = list[{idx, 2'b00} +: 4];
    return nib;
  endfunction

  // listed bits 4:1 plus base; interleave mode folds in the slice bit
  function automatic logic [4:0] iod_form(input logic [3:0] nib, input logic hemi,
                                          input logic slice, input logic idbase);
    logic [4:0] node_identifier;
    node_identifier = {nib[3:1], nib[0] ^ (hemi & slice), idbase};
    return node_identifier;
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] iod_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [11:0] up;
  logic low_alias;
  logic prot_alias;
  logic in_hole;
  logic in_rom;
  logic [2:0] rom_seg;
  logic rom_en_hit;
  logic [2:0] dram_idx;
  logic [2:0] idx_23_21;
  logic [4:0] node;
  iod_pkg::iod_attr_type attr;
  iod_pkg::iod_entry_type ent;
  logic hit;
  logic to_dram;
  logic abort;
  logic csr_win;
  logic acc;
  logic wr_now;
  logic [31:0] rd_mux;

  always_comb begin
    up = req_addr_in[43:32];
    low_alias = (up == iod_pkg::UP_LOW);
    prot_alias = (up == iod_pkg::UP_PROT) & req_protected_in;
    // the 64 MB hole below 4 GB never falls through to DRAM
    in_hole = (low_alias | (up == iod_pkg::UP_PROT))
              & (req_addr_in[31:26] == iod_pkg::HOLE_31_26) & ~req_io_space_in;
    in_rom = (req_addr_in[43:20] == iod_pkg::ROM_43_20)
             & (req_addr_in[19:18] == iod_pkg::ROM_19_18) & ~req_io_space_in;
    if (req_addr_in[17:16] == 2'b11) begin
      rom_seg = 3'd0;
    end else begin
      rom_seg = 3'(req_addr_in[17:15] + 3'd1);
    end
    rom_en_hit = req_write_in ? st_q.rom_en[iod_pkg::ROM_WR_LSB + 32'(rom_seg)]
                              : st_q.rom_en[rom_seg];
    if (st_q.dram_pay[iod_pkg::PAY_TGTSEL]) begin
      dram_idx = req_addr_in[8:6];
    end else begin
      dram_idx = req_addr_in[8:6] ^ req_addr_in[18:16];
    end
    // list entries use their fixed bits; index select is treated as set
    idx_23_21 = req_addr_in[23:21];
    abort = 1'b0;
    csr_win = 1'b0;
    node = 5'h00;
    attr = iod_pkg::ATTR_MMIO;
    ent = iod_pkg::ENT_NONE;
    hit = 1'b1;
    to_dram = 1'b0;
    if (req_io_space_in) begin
      // only legacy I/O space reaches this entry, and nothing else does
      if (st_q.valid[iod_pkg::VB_LEGIO]) begin
        ent = iod_pkg::ENT_LEGIO;
        node = st_q.hub_node;
        attr = iod_pkg::ATTR_IO;
      end else begin
        hit = 1'b0;
      end
    end else if (in_rom) begin
      if (rom_en_hit & ~req_cacheable_in) begin
        ent = iod_pkg::ENT_ROM;
        node = st_q.rom_node;
      end else begin
        hit = 1'b0;
        to_dram = 1'b1;
      end
    end else if (in_hole & (low_alias | prot_alias)
                 & (req_addr_in[31:20] == iod_pkg::LCFG_31_20)) begin
      ent = iod_pkg::ENT_LCFG;
      node = {1'b0, st_q.socket_id, iod_pkg::DEV_CFG_AGENT};
      abort = (req_addr_in[19:16] == iod_pkg::ABORT_19_16);
      csr_win = (req_addr_in[19:16] >= iod_pkg::CSR_WIN_LO)
                & (req_addr_in[19:16] <= iod_pkg::CSR_WIN_HI);
    end else if ((req_addr_in[31:24] == iod_pkg::SOCK_31_24) & in_hole
                 & ((low_alias & st_q.valid[iod_pkg::VB_SOCK_LO])
                 | (prot_alias & st_q.valid[iod_pkg::VB_SOCK_PR]))) begin
      ent = iod_pkg::ENT_SOCK;
      node = iod_form(iod_pick(st_q.sock_list, idx_23_21), st_q.list_pay[iod_pkg::PAY_HEMI],
                      req_slice_hemi_in, st_q.list_pay[iod_pkg::PAY_IDBASE]);
    end else if ((req_addr_in[31:24] == iod_pkg::CHIP_31_24) & in_hole
                 & ((low_alias & st_q.valid[iod_pkg::VB_CHIP_LO])
                 | (prot_alias & st_q.valid[iod_pkg::VB_CHIP_PR]))) begin
      ent = iod_pkg::ENT_CHIP;
      node = iod_form(iod_pick(st_q.chip_list, idx_23_21), st_q.list_pay[iod_pkg::PAY_HEMI],
                      req_slice_hemi_in, st_q.list_pay[iod_pkg::PAY_IDBASE]);
    end else if (low_alias & in_hole & (req_addr_in[31:20] == iod_pkg::INTC_31_20)
                 & st_q.valid[iod_pkg::VB_INTC]) begin
      ent = iod_pkg::ENT_INTC;
      node = iod_form(iod_pick(st_q.intc_list, req_addr_in[15:13]),
                      st_q.list_pay[iod_pkg::PAY_HEMI], req_slice_hemi_in,
                      st_q.list_pay[iod_pkg::PAY_IDBASE]);
    end else if (low_alias & in_hole & (req_addr_in[31:20] == iod_pkg::HUB_31_20)
                 & st_q.valid[iod_pkg::VB_HUB]) begin
      ent = iod_pkg::ENT_HUB;
      node = st_q.hub_node;
    end else if (low_alias & in_hole & (req_addr_in[31:24] == iod_pkg::FW_31_24)
                 & st_q.valid[iod_pkg::VB_FW]) begin
      ent = iod_pkg::ENT_FW;
      node = iod_form(iod_pick(st_q.fw_list, idx_23_21), st_q.list_pay[iod_pkg::PAY_HEMI],
                      req_slice_hemi_in, st_q.list_pay[iod_pkg::PAY_IDBASE]);
    end else if (in_hole) begin
      hit = 1'b0;
    end else begin
      hit = 1'b0;
      to_dram = 1'b1;
    end
    if (to_dram) begin
      ent = iod_pkg::ENT_DRAM;
      attr = iod_pkg::ATTR_DRAM;
      node = iod_form(iod_pick(st_q.dram_list, dram_idx), st_q.dram_pay[iod_pkg::PAY_HEMI],
                      req_slice_hemi_in, st_q.dram_pay[iod_pkg::PAY_IDBASE]);
    end else if (!hit) begin
      ent = iod_pkg::ENT_NONE;
      node = 5'h00;
    end
  end

  // register bus: one wait cycle, answer on the second edge
  always_comb begin
    acc = (avs_read_in | avs_write_in) & st_q.wait_n;
    wr_now = avs_write_in & ~st_q.wait_n;
    if (avs_address_in == iod_pkg::OFF_VALID) begin
      rd_mux = st_q.valid;
    end else if (avs_address_in == iod_pkg::OFF_BASE_CFG) begin
      rd_mux = st_q.base_cfg;
    end else if (avs_address_in == iod_pkg::OFF_ROM_EN) begin
      rd_mux = {18'h0_0000, st_q.rom_en};
    end else if (avs_address_in == iod_pkg::OFF_COMPAT_EN) begin
      rd_mux = st_q.compat_en;
    end else if (avs_address_in == iod_pkg::OFF_ROM_NODE) begin
      rd_mux = {27'h000_0000, st_q.rom_node};
    end else if (avs_address_in == iod_pkg::OFF_HUB_NODE) begin
      rd_mux = {27'h000_0000, st_q.hub_node};
    end else if (avs_address_in == iod_pkg::OFF_SOCK_LIST) begin
      rd_mux = st_q.sock_list;
    end else if (avs_address_in == iod_pkg::OFF_CHIP_LIST) begin
      rd_mux = st_q.chip_list;
    end else if (avs_address_in == iod_pkg::OFF_INTC_LIST) begin
      rd_mux = st_q.intc_list;
    end else if (avs_address_in == iod_pkg::OFF_FW_LIST) begin
      rd_mux = st_q.fw_list;
    end else if (avs_address_in == iod_pkg::OFF_LIST_PAY) begin
      rd_mux = {29'h0000_0000, st_q.list_pay};
    end else if (avs_address_in == iod_pkg::OFF_DRAM_PAY) begin
      rd_mux = {29'h0000_0000, st_q.dram_pay};
    end else if (avs_address_in == iod_pkg::OFF_DRAM_LIST) begin
      rd_mux = st_q.dram_list;
    end else if (avs_address_in == iod_pkg::OFF_SOCKET_ID) begin
      rd_mux = {30'h0000_0000, st_q.socket_id};
    end else if (avs_address_in == iod_pkg::OFF_LAST) begin
      rd_mux = {16'h0000, st_q.last};
    end else if (avs_address_in == iod_pkg::OFF_MISS_CNT) begin
      rd_mux = {16'h0000, st_q.miss_cnt};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.wait_n = ~acc;
    if (acc & avs_read_in) begin
      st_d.rdata = rd_mux;
    end
    if (wr_now) begin
      // payloads carry no useful default; software loads them before enabling
      if (avs_address_in == iod_pkg::OFF_VALID) begin
        st_d.valid = iod_merge(st_q.valid, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == iod_pkg::OFF_BASE_CFG) begin
        st_d.base_cfg = iod_merge(st_q.base_cfg, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == iod_pkg::OFF_ROM_EN) begin
        st_d.rom_en = 14'(iod_merge({18'h0_0000, st_q.rom_en}, avs_writedata_in,
                                    avs_byteenable_in));
      end else if (avs_address_in == iod_pkg::OFF_COMPAT_EN) begin
        st_d.compat_en = iod_merge(st_q.compat_en, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == iod_pkg::OFF_ROM_NODE && avs_byteenable_in[0]) begin
        st_d.rom_node = avs_writedata_in[4:0];
      end else if (avs_address_in == iod_pkg::OFF_HUB_NODE && avs_byteenable_in[0]) begin
        st_d.hub_node = avs_writedata_in[4:0];
      end else if (avs_address_in == iod_pkg::OFF_SOCK_LIST) begin
        st_d.sock_list = iod_merge(st_q.sock_list, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == iod_pkg::OFF_CHIP_LIST) begin
        st_d.chip_list = iod_merge(st_q.chip_list, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == iod_pkg::OFF_INTC_LIST) begin
        st_d.intc_list = iod_merge(st_q.intc_list, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == iod_pkg::OFF_FW_LIST) begin
        st_d.fw_list = iod_merge(st_q.fw_list, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == iod_pkg::OFF_LIST_PAY && avs_byteenable_in[0]) begin
        st_d.list_pay = avs_writedata_in[2:0];
      end else if (avs_address_in == iod_pkg::OFF_DRAM_PAY && avs_byteenable_in[0]) begin
        st_d.dram_pay = avs_writedata_in[2:0];
      end else if (avs_address_in == iod_pkg::OFF_DRAM_LIST) begin
        st_d.dram_list = iod_merge(st_q.dram_list, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == iod_pkg::OFF_SOCKET_ID && avs_byteenable_in[0]) begin
        st_d.socket_id = avs_writedata_in[1:0];
      end
    end
    // result registered one cycle after the request
    st_d.rsp_valid = req_valid_in;
    st_d.rsp_node = req_valid_in ? node : 5'h00;
    st_d.rsp_attr = attr;
    st_d.rsp_entry = req_valid_in ? ent : iod_pkg::ENT_NONE;
    st_d.rsp_dram = req_valid_in & to_dram;
    st_d.rsp_miss = req_valid_in & ~hit & ~to_dram;
    st_d.rsp_abort = req_valid_in & abort;
    st_d.rsp_no_alloc = req_valid_in & abort & req_cacheable_in;
    st_d.rsp_csr_win = req_valid_in & csr_win;
    if (req_valid_in) begin
      st_d.last = {req_valid_in & ~hit & ~to_dram, to_dram, 1'b0, ent, attr, 2'b00, node};
      if (~hit & ~to_dram && st_q.miss_cnt != 16'hffff) begin
        st_d.miss_cnt = 16'(st_q.miss_cnt + 16'(iod_pkg::CNT_ONE)); // saturates
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
      st_q.valid <= iod_pkg::VALID_RST;
      st_q.base_cfg <= iod_pkg::ZERO_RST;
      st_q.compat_en <= iod_pkg::ZERO_RST;
      st_q.wait_n <= 1'b1;
      st_q.rsp_attr <= iod_pkg::ATTR_MMIO;
      st_q.rsp_entry <= iod_pkg::ENT_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata_out = st_q.rdata;
  assign avs_waitrequest_out = st_q.wait_n;
  assign rsp_valid_out = st_q.rsp_valid;
  assign rsp_node_id_out = st_q.rsp_node;
  assign rsp_attr_out = st_q.rsp_attr;
  assign rsp_entry_out = st_q.rsp_entry;
  assign rsp_dram_out = st_q.rsp_dram;
  assign rsp_miss_out = st_q.rsp_miss;
  assign rsp_abort_out = st_q.rsp_abort;
  assign rsp_no_alloc_out = st_q.rsp_no_alloc;
  assign rsp_csr_window_out = st_q.rsp_csr_win;
endmodule // iod_decoder

// ==== tb/iod_decoder_sva.sv ====
// port assertions for the I/O decoder
module iod_decoder_sva (
  input wire logic clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic avs_read_in, // read
  input wire logic avs_write_in, // write
  input wire logic avs_waitrequest_out, // stall
  input wire logic req_valid_in, // request
  input wire logic [43:0] req_addr_in, // address
  input wire logic req_cacheable_in, // cacheable
  input wire logic req_io_space_in, // io space
  input wire logic rsp_valid_out, // result
  input wire logic [4:0] rsp_node_id_out, // node
  input wire iod_pkg::iod_attr_type rsp_attr_out, // attribute
  input wire iod_pkg::iod_entry_type rsp_entry_out, // entry
  input wire logic rsp_dram_out, // dram
  input wire logic rsp_miss_out, // miss
  input wire logic rsp_abort_out, // abort page
  input wire logic rsp_no_alloc_out, // no allocate
  input wire logic rsp_csr_window_out // register window
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lcfg, abort_hit, win_hit;
  // low alias only: the protected alias also hangs on the mode bit
  assign lcfg = !req_io_space_in && req_addr_in[43:20] == {12'h000, iod_pkg::LCFG_31_20};
  assign abort_hit = lcfg && req_addr_in[19:16] == iod_pkg::ABORT_19_16;
  assign win_hit = req_addr_in[19:16] inside {[iod_pkg::CSR_WIN_LO:iod_pkg::CSR_WIN_HI]};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  AST_RSP_NEXT: assert property (req_valid_in |=> rsp_valid_out)
    else $error("request not answered next cycle");
  AST_RSP_ONLY: assert property (!req_valid_in |=> !rsp_valid_out)
    else $error("result without request");
  AST_MISS_CLEAN: assert property (rsp_valid_out && rsp_miss_out |->
    rsp_entry_out == iod_pkg::ENT_NONE && !rsp_dram_out)
    else $error("miss carries a target");
  AST_LCFG_NODE: assert property (req_valid_in && lcfg |=>
    rsp_entry_out == iod_pkg::ENT_LCFG && rsp_node_id_out[4] == 1'b0 &&
    rsp_node_id_out[1:0] == iod_pkg::DEV_CFG_AGENT && rsp_attr_out == iod_pkg::ATTR_MMIO)
    else $error("local config target wrong");
  AST_ABORT_PAGE: assert property (req_valid_in && lcfg |=> rsp_abort_out == $past(abort_hit))
    else $error("abort flag wrong");
  AST_NO_ALLOC: assert property (req_valid_in && abort_hit && req_cacheable_in |=> rsp_no_alloc_out)
    else $error("abort page access may allocate");
  AST_CSR_WIN: assert property (req_valid_in && lcfg |=> rsp_csr_window_out == $past(win_hit))
    else $error("register window flag wrong");
  AST_IO_ONLY: assert property (req_valid_in && !req_io_space_in |=>
    rsp_entry_out != iod_pkg::ENT_LEGIO)
    else $error("memory request hit legacy io");
  AST_ROM_NC: assert property (req_valid_in && req_cacheable_in |=> rsp_entry_out != iod_pkg::ENT_ROM)
    else $error("cacheable request hit rom segment");
  AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=>
    !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("register access not one wait cycle");
  cover property (rsp_valid_out && rsp_entry_out == iod_pkg::ENT_ROM);
  cover property (rsp_valid_out && rsp_entry_out == iod_pkg::ENT_LEGIO);
  cover property (rsp_abort_out && rsp_no_alloc_out);
  cover property (rsp_valid_out && rsp_miss_out);
endmodule // iod_decoder_sva
bind iod_decoder iod_decoder_sva chk (.*);

// ==== tb/iod_core_model.sv ====
// core-side model issuing one decode request at a time
module iod_core_model (
  input wire logic clk_in, // uncore clock
  output logic req_valid_out, // request strobe
  output logic [43:0] req_addr_out, // address
  output logic req_write_out, // write
  output logic req_cacheable_out, // cacheable
  output logic req_protected_out, // protected mode
  output logic req_io_space_out, // legacy I/O space
  output logic req_hemi_out // slice id bit 2
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] fl;
  assign {req_write_out, req_cacheable_out, req_protected_out, req_io_space_out,
    req_hemi_out} = fl;
  initial begin
    req_valid_out = 1'b0;
    req_addr_out = 44'h0;
    fl = 5'h00;
  end
  // f is {write, cacheable, protected, io space, slice}
  task automatic issue(input logic [43:0] a, input logic [4:0] f);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_addr_out <= a;
    fl <= f;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    // released lines flip so a stale sample cannot look right
    req_addr_out <= ~a;
    fl <= ~f;
  endtask
endmodule // iod_core_model

// ==== tb/iod_decoder_bench.sv ====
// self-checking bench for the I/O decoder
module iod_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] RD = 5'h00, WR = 5'h10, CA = 5'h08, PR = 5'h04, IO = 5'h02, HM = 5'h01;
  localparam logic [4:0] DR = 5'h10, MS = 5'h08, AB = 5'h04, NA = 5'h02, CW = 5'h01;
  localparam logic [43:0] HOLE [5] = '{44'h0_fca0_0000, 44'h0_fda0_0000, 44'h0_fec0_a000,
    44'h0_fed0_0000, 44'h0_ffa0_0000};
  localparam logic [43:0] DA = 44'h1_0005_0140;
  localparam iod_pkg::iod_attr_type MM = iod_pkg::ATTR_MMIO, DM = iod_pkg::ATTR_DRAM;
  localparam iod_pkg::iod_entry_type ED = iod_pkg::ENT_DRAM, EL = iod_pkg::ENT_LCFG;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out, rd;
  logic [43:0] req_addr_in;
  logic [4:0] rsp_node_id_out;
  logic avs_waitrequest_out, req_valid_in, req_write_in, req_cacheable_in, req_protected_in;
  logic req_io_space_in, req_slice_hemi_in, rsp_valid_out, rsp_dram_out, rsp_miss_out;
  logic rsp_abort_out, rsp_no_alloc_out, rsp_csr_window_out;
  iod_pkg::iod_attr_type rsp_attr_out;
  iod_pkg::iod_entry_type rsp_entry_out;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2 clk_in = ~clk_in;
  iod_decoder DUT (.*);
  iod_core_model core (.clk_in, .req_valid_out(req_valid_in), .req_addr_out(req_addr_in),
    .req_write_out(req_write_in), .req_cacheable_out(req_cacheable_in),
    .req_protected_out(req_protected_in), .req_io_space_out(req_io_space_in),
    .req_hemi_out(req_slice_hemi_in));
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk_in);
    end
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n == 20) chk(32'h0, 32'h1);
  endtask
  // fl is {dram, miss, abort, no allocate, register window}
  task automatic req(input logic [43:0] a, input logic [4:0] f, input iod_pkg::iod_entry_type e,
      input logic [4:0] nd, input iod_pkg::iod_attr_type at, input logic [4:0] fl);
    core.issue(a, f);
    #1;
    if (fl[3]) chk({rsp_valid_out, rsp_entry_out}, {1'b1, e});
    else chk({rsp_valid_out, rsp_entry_out, rsp_node_id_out, rsp_attr_out}, {1'b1, e, nd, at});
    chk({rsp_dram_out, rsp_miss_out, rsp_abort_out, rsp_no_alloc_out, rsp_csr_window_out}, fl);
  endtask
  task automatic t_reset;
    bus(1'b1, 8'h40, 32'hffff_ffff);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, i == 4 ? 8'h40 : iod_pkg::OFF_VALID + 8'(4 * i), 32'h0);
      chk(rd, i == 0 ? iod_pkg::VALID_RST : iod_pkg::ZERO_RST);
    end
    $display("reset values done");
  endtask
  task automatic t_lcfg;
    bus(1'b1, iod_pkg::OFF_SOCKET_ID, 32'h2);
    req(44'h0_feb0_0040, CA, EL, 5'h0a, MM, AB | NA);
    req(44'h0_feb2_0000, RD, EL, 5'h0a, MM, CW);
    req(44'hff0_feb3_0000, PR, EL, 5'h0a, MM, CW);
    req(44'h0_feb4_0000, WR, EL, 5'h0a, MM, 5'h00);
    $display("local config done");
  endtask
  task automatic t_hole_off;
    for (int i = 0; i < 5; i++)
      req(HOLE[i], RD, iod_pkg::ENT_NONE, 5'h00, MM, MS);
    $display("disabled regions done");
  endtask
  task automatic t_lists;
    for (int k = 0; k < 4; k++)
      bus(1'b1, iod_pkg::OFF_SOCK_LIST + 8'(4 * k), 32'h7654_3210 + 32'h1111_1111 * k);
    bus(1'b1, iod_pkg::OFF_LIST_PAY, 32'h1); // idbase set, interleave clear
    bus(1'b1, iod_pkg::OFF_HUB_NODE, 32'h6);
    bus(1'b1, iod_pkg::OFF_VALID, 32'h01f8_0006);
    req(HOLE[0], HM, iod_pkg::ENT_SOCK, 5'h0b, MM, 5'h00);
    req(44'hff0_fca0_0000, PR, iod_pkg::ENT_SOCK, 5'h0b, MM, 5'h00);
    req(44'hff0_fda0_0000, RD, iod_pkg::ENT_NONE, 5'h00, MM, MS);
    req(HOLE[1], RD, iod_pkg::ENT_CHIP, 5'h0d, MM, 5'h00);
    req(HOLE[2], RD, iod_pkg::ENT_INTC, 5'h0f, MM, 5'h00);
    req(HOLE[3], RD, iod_pkg::ENT_HUB, 5'h06, MM, 5'h00);
    req(HOLE[4], RD, iod_pkg::ENT_FW, 5'h11, MM, 5'h00);
    req(44'h0, IO, iod_pkg::ENT_LEGIO, 5'h06, iod_pkg::ATTR_IO, 5'h00);
    $display("list entries done");
  endtask
  task automatic t_dram;
    bus(1'b1, iod_pkg::OFF_DRAM_LIST, 32'h3210_7654);
    bus(1'b1, iod_pkg::OFF_DRAM_PAY, 32'h3);
    req(DA, HM, ED, 5'h0b, DM, DR);
    bus(1'b1, iod_pkg::OFF_DRAM_PAY, 32'h7);
    req(DA, HM, ED, 5'h01, DM, DR);
    req(DA, RD, ED, 5'h03, DM, DR);
    $display("dram targets done");
  endtask
  task automatic t_rom;
    bus(1'b1, iod_pkg::OFF_ROM_NODE, 32'h4);
    bus(1'b1, iod_pkg::OFF_ROM_EN, 32'h2002);
    req(44'hc_0000, RD, iod_pkg::ENT_ROM, 5'h04, MM, 5'h00);
    req(44'hc_0000, CA, ED, 5'h09, DM, DR);
    req(44'hc_0000, WR, ED, 5'h09, DM, DR);
    req(44'he_8000, WR, iod_pkg::ENT_ROM, 5'h04, MM, 5'h00);
    req(44'he_8000, RD, ED, 5'h09, DM, DR);
    req(44'hf_0000, RD, ED, 5'h09, DM, DR);
    $display("rom segments done");
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_lcfg();
    t_hole_off();
    t_lists();
    t_dram();
    t_rom();
    summarize();
  end
endmodule // iod_decoder_bench
